/* rtl/eemc_page_buf.sv */
/*
 * Sixteen-byte page buffer held in flip-flops.
 * Assumes one write port and one read port on the same clock.
 */
`timescale 1ns/1ps
`include "eemc_map.svh"
`default_nettype none

module eemc_page_buf (
    input  wire logic       sys_clk,
    input  wire logic       sys_rst,
    input  wire logic       wr_en,
    input  wire logic [3:0] wr_idx,
    input  wire logic [7:0] wr_data,
    input  wire logic [3:0] rd_idx,
    output logic      [7:0] rd_data
);

    typedef struct packed {
        logic [`EEMC_PAGE_BYTES-1:0][7:0] mem;
    } eemc_page_buf_s;

    eemc_page_buf_s q;
    eemc_page_buf_s d;

    // Read straight from the stored bytes
    assign rd_data = q.mem[rd_idx];

    // Each entry takes the write data when its index is addressed
    always_comb begin
        d = q;
        for (int i = 0; i < `EEMC_PAGE_BYTES; i++) begin
            if (wr_en && (wr_idx == 4'(i))) begin
                d.mem[i] = wr_data;
            end
        end
    end

    // State register
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

endmodule

`default_nettype wire

/* rtl/eemc_timer.sv */
/*
 * Down counter that times one erase or write cycle.
 * Assumes start is a one-cycle pulse and load is at least 1.
 */
`timescale 1ns/1ps
`default_nettype none

module eemc_timer (
    input  wire logic                  sys_clk,
    input  wire logic                  sys_rst,
    input  wire logic                  start,
    input  wire eemc_pkg::eemc_count_t load,
    output logic                       done
);

    typedef struct packed {
        eemc_pkg::eemc_count_t cnt;
    } eemc_timer_s;

    eemc_timer_s q;
    eemc_timer_s d;

    // Done in the last counted cycle, so a cycle spans exactly load cycles
    assign done = (q.cnt == 16'h0001);

    // Load on start, otherwise count down to zero
    always_comb begin
        d = q;
        if (start) begin
            d.cnt = load;
        end else if (q.cnt != 16'h0000) begin
            d.cnt = q.cnt - 16'h0001;
        end
    end

    // State register
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

endmodule

`default_nettype wire

/* rtl/eemc_top.sv */
/*
 * Data EEPROM control block: control, address and data registers on a
 * classic Wishbone slave, erase/write/read sequencing with timed cycles,
 * byte or page mode and a sixteen-byte page buffer.
 * Assumes the array takes a one-cycle command strobe and returns read
 * data in the same cycle as its read strobe.
 */
`timescale 1ns/1ps
`include "eemc_map.svh"
`default_nettype none

module eemc_top #(
    parameter logic [15:0] ERASE_T0_CYC = 16'(`EEMC_ERASE_T0_CYC),
    parameter logic [15:0] ERASE_T1_CYC = 16'(`EEMC_ERASE_T1_CYC),
    parameter logic [15:0] WRITE_T0_CYC = 16'(`EEMC_WRITE_T0_CYC),
    parameter logic [15:0] WRITE_T1_CYC = 16'(`EEMC_WRITE_T1_CYC)
) (
    input  wire logic        sys_clk,
    input  wire logic        sys_rst,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    output logic      [9:0]  arr_addr,
    output logic      [7:0]  arr_wdata,
    output logic             arr_we,
    output logic             arr_erase,
    output logic             arr_re,
    output logic             arr_page,
    input  wire logic [7:0]  arr_rdata
);

    typedef struct packed {
        logic [7:0]            ctrl;
        logic [7:0]            alo;
        logic [1:0]            ahi;
        logic [7:0]            data;
        eemc_pkg::eemc_state_e st;
        logic                  ack;
        logic [7:0]            rdat;
        logic [9:0]            arr_addr;
        logic [7:0]            arr_wdata;
        logic                  arr_we;
        logic                  arr_erase;
        logic                  arr_re;
        logic                  arr_page;
        logic                  push_act;
        logic [3:0]            push_idx;
        logic [15:0]           elapsed;
    } eemc_top_s;

    eemc_top_s q;
    eemc_top_s d;

    logic                  tmr_start;
    eemc_pkg::eemc_count_t tmr_load;
    logic                  tmr_done;
    logic                  buf_we;
    logic [7:0]            buf_rdata;
    logic                  wr_go;
    logic                  ctl_wr;
    eemc_pkg::eemc_slot_e  slot;
    logic [7:0]            nv;
    logic                  erase_ok;
    logic                  write_ok;
    logic                  read_ok;

    // Bus address to register slot
    function automatic eemc_pkg::eemc_slot_e reg_slot(input logic [7:0] a);
        case (a)
            `EEMC_ADR_CTRL:    return eemc_pkg::EEMC_SLOT_CTRL;
            `EEMC_ADR_ADDR_LO: return eemc_pkg::EEMC_SLOT_ALO;
            `EEMC_ADR_ADDR_HI: return eemc_pkg::EEMC_SLOT_AHI;
            `EEMC_ADR_DATA:    return eemc_pkg::EEMC_SLOT_DATA;
            default:           return eemc_pkg::EEMC_SLOT_NONE;
        endcase
    endfunction

    // Low nibble step that stops at the page end
    function automatic logic [7:0] step_low(input logic [7:0] a);
        return (a[3:0] == `EEMC_PAGE_LAST) ? a : a + 8'h01;
    endfunction

    eemc_timer eemc_timer_inst (
        .sys_clk (sys_clk),
        .sys_rst (sys_rst),
        .start   (tmr_start),
        .load    (tmr_load),
        .done    (tmr_done)
    );

    // Page data collected here before a page write
    eemc_page_buf eemc_page_buf_inst (
        .sys_clk (sys_clk),
        .sys_rst (sys_rst),
        .wr_en   (buf_we),
        .wr_idx  (q.alo[3:0]),
        .wr_data (wb_dat_i[7:0]),
        .rd_idx  (q.push_idx),
        .rd_data (buf_rdata)
    );

    // Bus decode; a write lands at the edge where ack is high
    assign slot   = reg_slot(wb_adr_i);
    assign wr_go  = wb_cyc_i && wb_stb_i && wb_we_i && q.ack && wb_sel_i[0];
    assign ctl_wr = wr_go && (slot == eemc_pkg::EEMC_SLOT_CTRL)
                    && (q.st == eemc_pkg::EEMC_IDLE);
    assign nv     = wb_dat_i[7:0];

    // Trigger acceptance: erase first, then write, then read only if no write trigger
    assign erase_ok = nv[`EEMC_CTL_ETRG] && nv[`EEMC_CTL_EEN]
                      && q.ctrl[`EEMC_CTL_EEN];
    assign write_ok = nv[`EEMC_CTL_WTRG] && nv[`EEMC_CTL_WEN]
                      && q.ctrl[`EEMC_CTL_WEN] && !erase_ok;
    assign read_ok  = nv[`EEMC_CTL_RTRG] && nv[`EEMC_CTL_REN]
                      && q.ctrl[`EEMC_CTL_REN] && !erase_ok
                      && !nv[`EEMC_CTL_WTRG];

    // Next state: bus side first, sequencer second so it wins on overlap
    always_comb begin
        d           = q;
        d.arr_we    = 1'b0;
        d.arr_erase = 1'b0;
        d.arr_re    = 1'b0;
        tmr_start   = 1'b0;
        tmr_load    = 16'h0000;
        buf_we      = 1'b0;
        d.ack       = wb_cyc_i && wb_stb_i && !q.ack;
        if (wb_cyc_i && wb_stb_i && !q.ack) begin
            case (slot)
                eemc_pkg::EEMC_SLOT_CTRL: d.rdat = q.ctrl;
                eemc_pkg::EEMC_SLOT_ALO:  d.rdat = q.alo;
                eemc_pkg::EEMC_SLOT_AHI:  d.rdat = {6'h00, q.ahi};
                eemc_pkg::EEMC_SLOT_DATA: d.rdat = q.data;
                default:                  d.rdat = 8'h00;
            endcase
        end
        if (ctl_wr) begin
            d.ctrl                 = nv;
            d.ctrl[`EEMC_CTL_ETRG] = erase_ok;
            d.ctrl[`EEMC_CTL_WTRG] = write_ok;
            d.ctrl[`EEMC_CTL_RTRG] = read_ok;
            if (erase_ok) begin
                d.st        = eemc_pkg::EEMC_ERASE;
                d.arr_erase = 1'b1;
                d.arr_page  = nv[`EEMC_CTL_MODE];
                d.arr_addr  = nv[`EEMC_CTL_MODE]
                              ? {q.ahi, q.alo[7:4], 4'h0}
                              : {q.ahi, q.alo};
                tmr_start   = 1'b1;
                tmr_load    = nv[`EEMC_CTL_TSEL] ? ERASE_T1_CYC
                                                 : ERASE_T0_CYC;
            end else if (write_ok) begin
                d.st       = eemc_pkg::EEMC_WRITE;
                tmr_start  = 1'b1;
                tmr_load   = nv[`EEMC_CTL_TSEL] ? WRITE_T1_CYC
                                                : WRITE_T0_CYC;
                d.arr_page = nv[`EEMC_CTL_MODE];
                if (nv[`EEMC_CTL_MODE]) begin
                    d.push_act = 1'b1;
                    d.push_idx = 4'h0;
                end else begin
                    d.arr_we    = 1'b1;
                    d.arr_wdata = q.data;
                    d.arr_addr  = {q.ahi, q.alo};
                end
            end else if (read_ok) begin
                d.st       = eemc_pkg::EEMC_READ;
                d.arr_re   = 1'b1;
                d.arr_page = nv[`EEMC_CTL_MODE];
                d.arr_addr = {q.ahi, q.alo};
            end
        end else if (wr_go) begin
            case (slot)
                eemc_pkg::EEMC_SLOT_ALO: d.alo = nv;
                eemc_pkg::EEMC_SLOT_AHI: d.ahi = nv[1:0];
                eemc_pkg::EEMC_SLOT_DATA: begin
                    d.data = nv;
                    if (q.ctrl[`EEMC_CTL_MODE]) begin
                        buf_we = 1'b1;
                        d.alo  = step_low(q.alo);
                    end
                end
                default: d.data = q.data;
            endcase
        end
        // Sequencer
        unique case (q.st)
            eemc_pkg::EEMC_IDLE: begin
                d.push_act = d.push_act;
            end
            eemc_pkg::EEMC_ERASE: begin
                if (tmr_done) begin
                    d.st                   = eemc_pkg::EEMC_IDLE;
                    d.ctrl[`EEMC_CTL_ETRG] = 1'b0;
                    d.ctrl[`EEMC_CTL_EEN]  = 1'b0;
                end
            end
            eemc_pkg::EEMC_WRITE: begin
                if (q.push_act) begin
                    d.arr_we    = 1'b1;
                    d.arr_wdata = buf_rdata;
                    d.arr_addr  = {q.ahi, q.alo[7:4], q.push_idx};
                    d.push_idx  = q.push_idx + 4'h1;
                    d.push_act  = (q.push_idx != `EEMC_PAGE_LAST);
                end
                if (tmr_done) begin
                    d.st                   = eemc_pkg::EEMC_IDLE;
                    d.push_act             = 1'b0;
                    d.ctrl[`EEMC_CTL_WTRG] = 1'b0;
                    d.ctrl[`EEMC_CTL_WEN]  = 1'b0;
                end
            end
            eemc_pkg::EEMC_READ: begin
                d.st                   = eemc_pkg::EEMC_IDLE;
                d.data                 = arr_rdata;
                d.ctrl[`EEMC_CTL_RTRG] = 1'b0;
                if (q.ctrl[`EEMC_CTL_MODE]) begin
                    d.alo = step_low(q.alo);
                end
            end
        endcase
        // Cycles spent in the running timed operation, for the length checks
        if (tmr_start) begin
            d.elapsed = 16'h0000;
        end else if (q.st != eemc_pkg::EEMC_IDLE) begin
            d.elapsed = q.elapsed + 16'h0001;
        end
    end

    // State register; reset clears every control bit
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            q      <= '0;
            q.ctrl <= `EEMC_CTRL_RST;
        end else begin
            q <= d;
        end
    end

    // Outputs straight from flip-flops
    assign wb_dat_o  = {24'h000000, q.rdat};
    assign wb_ack_o  = q.ack;
    assign arr_addr  = q.arr_addr;
    assign arr_wdata = q.arr_wdata;
    assign arr_we    = q.arr_we;
    assign arr_erase = q.arr_erase;
    assign arr_re    = q.arr_re;
    assign arr_page  = q.arr_page;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);

    sequence s_ctl_erase;
        ctl_wr && nv[`EEMC_CTL_ETRG] && nv[`EEMC_CTL_EEN]
        && q.ctrl[`EEMC_CTL_EEN];
    endsequence

    sequence s_erase_run;
        (q.st == eemc_pkg::EEMC_ERASE) && q.arr_erase
        ##1 (q.st == eemc_pkg::EEMC_ERASE) && !q.arr_erase;
    endsequence

    a_erase_start: assert property (s_ctl_erase |=> s_erase_run)
        else $error("Accepted erase trigger did not start an erase");

    a_erase_blocked: assert property (
        ctl_wr && nv[`EEMC_CTL_ETRG] && !q.ctrl[`EEMC_CTL_EEN]
        |=> (q.st != eemc_pkg::EEMC_ERASE) && !q.ctrl[`EEMC_CTL_ETRG]
            && !q.arr_erase)
        else $error("Erase started without prior erase enable");

    a_erase_needs_en: assert property (
        q.arr_erase |-> $past(q.ctrl[`EEMC_CTL_EEN]))
        else $error("Erase strobe while erase enable was clear");

    a_erase_done_clr: assert property (
        (q.st == eemc_pkg::EEMC_ERASE) && tmr_done
        |=> (q.st == eemc_pkg::EEMC_IDLE) && !q.ctrl[`EEMC_CTL_ETRG]
            && !q.ctrl[`EEMC_CTL_EEN])
        else $error("Erase end did not clear trigger and enable");

    a_erase_length: assert property (
        (q.st == eemc_pkg::EEMC_ERASE) && tmr_done
        |-> q.elapsed + 16'h0001 == (q.ctrl[`EEMC_CTL_TSEL]
            ? ERASE_T1_CYC : ERASE_T0_CYC))
        else $error("Erase cycle length wrong for time select");

    a_write_length: assert property (
        (q.st == eemc_pkg::EEMC_WRITE) && tmr_done
        |-> q.elapsed + 16'h0001 == (q.ctrl[`EEMC_CTL_TSEL]
            ? WRITE_T1_CYC : WRITE_T0_CYC))
        else $error("Write cycle length wrong for time select");

    a_write_blocked: assert property (
        ctl_wr && nv[`EEMC_CTL_WTRG] && !q.ctrl[`EEMC_CTL_WEN]
        |=> (q.st != eemc_pkg::EEMC_WRITE) && !q.arr_we)
        else $error("Write started without prior write enable");

    a_page_saturate: assert property (
        (q.st == eemc_pkg::EEMC_READ) && q.ctrl[`EEMC_CTL_MODE]
        && (q.alo[3:0] == `EEMC_PAGE_LAST) && !wr_go
        |=> (q.alo == $past(q.alo)))
        else $error("Page address rolled past the page end");

    a_page_step: assert property (
        (q.st == eemc_pkg::EEMC_READ) && q.ctrl[`EEMC_CTL_MODE]
        && (q.alo[3:0] != `EEMC_PAGE_LAST) && !wr_go
        |=> (q.alo[3:0] == $past(q.alo[3:0]) + 4'h1))
        else $error("Page read did not advance the address");

    a_byte_hold: assert property (
        (q.st == eemc_pkg::EEMC_READ) && !q.ctrl[`EEMC_CTL_MODE] && !wr_go
        |=> $stable(q.alo))
        else $error("Byte mode read changed the address");

    a_page_push_end: assert property (
        q.push_act && (q.push_idx == `EEMC_PAGE_LAST)
        |=> !q.push_act && q.arr_we && q.arr_addr[3:0] == 4'hF)
        else $error("Page push did not end after sixteen bytes");

    a_reset_clear: assert property (
        @(posedge sys_clk) disable iff (1'b0)
        sys_rst |=> (q.ctrl == 8'h00))
        else $error("Control register not cleared by reset");

endmodule

`default_nettype wire

/* shared/eemc_map.svh */
/*
 * Register map, control field positions, reset values and timing counts
 * for the data EEPROM control block.
 * Assumes a 10 MHz system clock and a 32-bit Wishbone register bus.
 */
`ifndef EEMC_MAP_SVH
`define EEMC_MAP_SVH

// Byte offsets of the registers on the bus
`define EEMC_ADR_CTRL      8'h00
`define EEMC_ADR_ADDR_LO   8'h04
`define EEMC_ADR_ADDR_HI   8'h08
`define EEMC_ADR_DATA      8'h0C

// Field positions in the control register
`define EEMC_CTL_TSEL      7
`define EEMC_CTL_EEN       6
`define EEMC_CTL_ETRG      5
`define EEMC_CTL_MODE      4
`define EEMC_CTL_WEN       3
`define EEMC_CTL_WTRG      2
`define EEMC_CTL_REN       1
`define EEMC_CTL_RTRG      0

// Reset values
`define EEMC_CTRL_RST      8'h00
`define EEMC_ADDR_LO_RST   8'h00
`define EEMC_ADDR_HI_RST   2'h0
`define EEMC_DATA_RST      8'h00

// Page geometry
`define EEMC_PAGE_BYTES    16
`define EEMC_PAGE_LAST     4'hF

// Clock period in nanoseconds and cycle durations in microseconds
`define EEMC_CLK_NS        100
`define EEMC_ERASE_T0_US   3200
`define EEMC_ERASE_T1_US   3700
`define EEMC_WRITE_T0_US   2200
`define EEMC_WRITE_T1_US   3000
`define EEMC_US2CYC(us)    (((us) * 1000 + `EEMC_CLK_NS - 1) / `EEMC_CLK_NS)
`define EEMC_ERASE_T0_CYC  `EEMC_US2CYC(`EEMC_ERASE_T0_US)
`define EEMC_ERASE_T1_CYC  `EEMC_US2CYC(`EEMC_ERASE_T1_US)
`define EEMC_WRITE_T0_CYC  `EEMC_US2CYC(`EEMC_WRITE_T0_US)
`define EEMC_WRITE_T1_CYC  `EEMC_US2CYC(`EEMC_WRITE_T1_US)

`endif

/* shared/eemc_pkg.sv */
/*
 * Types shared by the data EEPROM control block.
 * Assumes eemc_map.svh for all numeric constants.
 */
package eemc_pkg;

    // Operation sequencer states
    typedef enum logic [1:0] {
        EEMC_IDLE  = 2'b00,
        EEMC_ERASE = 2'b01,
        EEMC_WRITE = 2'b10,
        EEMC_READ  = 2'b11
    } eemc_state_e;

    // Register slot decoded from a bus address
    typedef enum logic [2:0] {
        EEMC_SLOT_CTRL = 3'b000,
        EEMC_SLOT_ALO  = 3'b001,
        EEMC_SLOT_AHI  = 3'b010,
        EEMC_SLOT_DATA = 3'b011,
        EEMC_SLOT_NONE = 3'b100
    } eemc_slot_e;

    typedef logic [15:0] eemc_count_t;

endpackage

/* test/tb_eemc_top.sv */
/*
 * Self-checking bench for the data EEPROM control block: register bus,
 * timed erase and write cycles, trigger refusal, byte and page modes.
 * Assumes eemc_top with shortened cycle counts and a 10 MHz clock.
 */
`timescale 1ns/1ps
`include "eemc_map.svh"
`default_nettype none

module tb_eemc_top;
    localparam int ET0 = 40;
    localparam int ET1 = 50;
    localparam int WT0 = 30;
    localparam int WT1 = 35;

    logic        sys_clk;
    logic        sys_rst;
    logic        wb_cyc_i;
    logic        wb_stb_i;
    logic        wb_we_i;
    logic [7:0]  wb_adr_i;
    logic [3:0]  wb_sel_i;
    logic [31:0] wb_dat_i;
    logic [31:0] wb_dat_o;
    logic        wb_ack_o;
    logic [9:0]  arr_addr;
    logic [7:0]  arr_wdata;
    logic        arr_we;
    logic        arr_erase;
    logic        arr_re;
    logic        arr_page;
    logic [7:0]  arr_rdata;
    int          err_count;
    int          checks_done;
    int          erases;
    int          cycles;
    integer      seed;
    logic [7:0]  rq[$];
    logic [20:0] aq[$];
    logic [7:0]  pbuf[16];

    eemc_top #(
        .ERASE_T0_CYC(16'(ET0)),
        .ERASE_T1_CYC(16'(ET1)),
        .WRITE_T0_CYC(16'(WT0)),
        .WRITE_T1_CYC(16'(WT1))
    ) eemc_top_inst (
        .sys_clk  (sys_clk),
        .sys_rst  (sys_rst),
        .wb_cyc_i (wb_cyc_i),
        .wb_stb_i (wb_stb_i),
        .wb_we_i  (wb_we_i),
        .wb_adr_i (wb_adr_i),
        .wb_sel_i (wb_sel_i),
        .wb_dat_i (wb_dat_i),
        .wb_dat_o (wb_dat_o),
        .wb_ack_o (wb_ack_o),
        .arr_addr (arr_addr),
        .arr_wdata(arr_wdata),
        .arr_we   (arr_we),
        .arr_erase(arr_erase),
        .arr_re   (arr_re),
        .arr_page (arr_page),
        .arr_rdata(arr_rdata)
    );

    // Free-running system clock
    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end

    task automatic chk(input string what, input logic [31:0] e, got);
        checks_done++;
        if (got !== e) begin
            err_count++;
            $display("unexpected %s: expected %h, seen %h", what, e, got);
        end
    endtask

    task automatic close_out;
        $display("checks %0d, mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // Watcher: compares read data and array strobes with the oldest note
    always @(posedge sys_clk) begin
        if (wb_ack_o === 1'b1 && wb_we_i === 1'b0) begin
            if (rq.size() == 0) chk("unnoted read", 32'h0, 32'h1);
            else chk("read data", {24'h0, rq.pop_front()}, wb_dat_o);
        end
        // Every array strobe, with its kind, page flag, address and data
        if (arr_we === 1'b1 || arr_erase === 1'b1 || arr_re === 1'b1) begin
            if (aq.size() == 0) chk("unnoted array strobe", 32'h0, 32'h1);
            else chk("array strobe", {11'h0, aq.pop_front()},
                     {11'h0, arr_erase, arr_re, arr_page, arr_addr,
                      (arr_we ? arr_wdata : 8'h00)});
        end
        if (arr_erase === 1'b1) erases++;
        cycles++;
        if (cycles == 3000) begin
            err_count++;
            close_out();
        end
    end

    // One classic Wishbone cycle, held until ack is sampled high
    task automatic bus(input logic w, input logic [7:0] a, d);
        @(posedge sys_clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= w;
        wb_adr_i <= a;
        wb_sel_i <= {3'($random(seed)), 1'b1};
        wb_dat_i <= {24'($random(seed)), d};
        do @(posedge sys_clk); while (wb_ack_o !== 1'b1);
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, d);
        bus(1'b1, a, d);
    endtask

    task automatic rd(input logic [7:0] a, e);
        rq.push_back(e);
        bus(1'b0, a, 8'h00);
    endtask

    // Start a timed cycle; bits stay set before n cycles, clear after
    task automatic timed(input logic [7:0] base, en, trg, input int n);
        wr(`EEMC_ADR_CTRL, base | en);
        wr(`EEMC_ADR_CTRL, base | en | trg);
        repeat (n - 6) @(posedge sys_clk);
        rd(`EEMC_ADR_CTRL, base | en | trg);
        repeat (8) @(posedge sys_clk);
        rd(`EEMC_ADR_CTRL, base);
    endtask

    // Main sequence
    initial begin
        logic [7:0] al;
        logic [7:0] d;
        logic [1:0] ah;
        int         i;
        seed = 32'hf742;
        err_count = 0;
        checks_done = 0;
        erases = 0;
        cycles = 0;
        sys_rst = 1'b1;
        wb_cyc_i = 1'b0;
        wb_stb_i = 1'b0;
        wb_we_i = 1'b0;
        wb_adr_i = 8'h00;
        wb_sel_i = 4'h0;
        wb_dat_i = 32'h0;
        arr_rdata = 8'($random(seed));
        repeat (6) @(posedge sys_clk);
        sys_rst <= 1'b0;
        rd(`EEMC_ADR_CTRL, 8'h00);
        rd(`EEMC_ADR_ADDR_LO, 8'h00);
        rd(`EEMC_ADR_ADDR_HI, 8'h00);
        rd(`EEMC_ADR_DATA, 8'h00);
        // Triggers without a prior enable are refused
        wr(`EEMC_ADR_CTRL, 8'h64);
        rd(`EEMC_ADR_CTRL, 8'h40);
        wr(`EEMC_ADR_CTRL, 8'h24);
        rd(`EEMC_ADR_CTRL, 8'h00);
        wr(8'h10, 8'h5A);
        rd(8'h10, 8'h00);
        chk("erase strobes", 32'h0, 32'(erases));
        aq.push_back({3'b100, 10'h000, 8'h00});
        timed(8'h00, 8'h40, 8'h20, ET0);
        aq.push_back({3'b100, 10'h000, 8'h00});
        timed(8'h80, 8'h40, 8'h20, ET1);
        chk("erase strobes", 32'h2, 32'(erases));
        // Byte writes at both time selects
        for (i = 0; i < 2; i++) begin
            al = 8'($random(seed));
            ah = 2'($random(seed));
            d = 8'($random(seed));
            wr(`EEMC_ADR_ADDR_LO, al);
            wr(`EEMC_ADR_ADDR_HI, {6'h0, ah});
            wr(`EEMC_ADR_DATA, d);
            aq.push_back({3'b000, ah, al, d});
            timed({i[0], 7'h0}, 8'h08, 8'h04, (i == 1) ? WT1 : WT0);
        end
        // Page fill past the boundary, then page write
        wr(`EEMC_ADR_ADDR_LO, 8'h50);
        wr(`EEMC_ADR_ADDR_HI, 8'h01);
        wr(`EEMC_ADR_CTRL, 8'h10);
        for (i = 0; i < 18; i++) begin
            d = 8'($random(seed));
            pbuf[(i > 15) ? 15 : i] = d;
            wr(`EEMC_ADR_DATA, d);
        end
        rd(`EEMC_ADR_ADDR_LO, 8'h5F);
        for (i = 0; i < 16; i++) begin
            aq.push_back({3'b001, 2'h1, 4'h5, i[3:0], pbuf[i]});
        end
        timed(8'h10, 8'h08, 8'h04, WT0);
        // Byte read; read trigger only, never with the write trigger
        wr(`EEMC_ADR_CTRL, 8'h02);
        aq.push_back({3'b010, 10'h15F, 8'h00});
        wr(`EEMC_ADR_CTRL, 8'h03);
        repeat (2) @(posedge sys_clk);
        rd(`EEMC_ADR_CTRL, 8'h02);
        rd(`EEMC_ADR_DATA, arr_rdata);
        // Page erase clears the low nibble; page reads step, then stop at F
        aq.push_back({3'b101, 10'h150, 8'h00});
        timed(8'h10, 8'h40, 8'h20, ET0);
        wr(`EEMC_ADR_ADDR_LO, 8'h5E);
        wr(`EEMC_ADR_CTRL, 8'h12);
        arr_rdata <= 8'($random(seed));
        aq.push_back({3'b011, 10'h15E, 8'h00});
        aq.push_back({3'b011, 10'h15F, 8'h00});
        wr(`EEMC_ADR_CTRL, 8'h13);
        wr(`EEMC_ADR_CTRL, 8'h13);
        rd(`EEMC_ADR_ADDR_LO, 8'h5F);
        rd(`EEMC_ADR_DATA, arr_rdata);
        // Reset in mid-run clears a control register that holds ones
        @(posedge sys_clk);
        sys_rst <= 1'b1;
        repeat (2) @(posedge sys_clk);
        sys_rst <= 1'b0;
        rd(`EEMC_ADR_CTRL, 8'h00);
        rd(`EEMC_ADR_ADDR_LO, 8'h00);
        repeat (4) @(posedge sys_clk);
        chk("pending notes", 32'h0, 32'(rq.size() + aq.size()));
        close_out();
    end
endmodule
`default_nettype wire
